// ---- hdl/asp_host.v ----
`timescale 1ns/100ps
`include "asp_consts.vh"
module asp_host #(
  parameter POWER_UP_CYC = `ASP_POWER_UP_WAIT_CYC,
  parameter ACCESS_CYC = `ASP_ACCESS_CYC,
  parameter WRITE_CYC = `ASP_WRITE_CYC
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire req_valid_i,
  input wire req_write_i,
  input wire [`ASP_ADDR_W-1:0] req_addr_i,
  input wire [`ASP_DATA_W-1:0] req_wdata_i,
  output wire req_ready_o,
  output reg rsp_valid_o,
  output reg [`ASP_DATA_W-1:0] rsp_rdata_o,
  input wire retention_req_i,
  output reg retention_ok_o,
  output reg select_low_active_b_o,
  output reg select_high_active_o,
  output reg output_enable_b_o,
  output reg write_strobe_b_o,
  output reg [`ASP_ADDR_W-1:0] word_select_lines_o,
  input wire [`ASP_DATA_W-1:0] shared_data_lines_i,
  output reg [`ASP_DATA_W-1:0] shared_data_lines_o,
  output reg shared_data_lines_oe_o
);
  localparam [2:0] ST_POWER = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_READ = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_WREND = 3'h4;
  localparam [2:0] ST_RETAIN = 3'h5;
  localparam [31:0] POWER_FULL = POWER_UP_CYC;
  localparam [31:0] ACCESS_FULL = ACCESS_CYC - 1;
  localparam [31:0] WRITE_FULL = WRITE_CYC - 1;
  localparam [31:0] SETTLE_FULL = `ASP_DESELECT_TO_RETENTION_CYC;
  localparam [`ASP_CNT_W-1:0] LOAD_POWER = POWER_FULL[`ASP_CNT_W-1:0];
  localparam [`ASP_CNT_W-1:0] LOAD_ACCESS = ACCESS_FULL[`ASP_CNT_W-1:0];
  localparam [`ASP_CNT_W-1:0] LOAD_WRITE = WRITE_FULL[`ASP_CNT_W-1:0];
  localparam [`ASP_CNT_W-1:0] LOAD_SETTLE = SETTLE_FULL[`ASP_CNT_W-1:0];

  reg [2:0] state;
  reg [2:0] next_state;
  reg load;
  reg [`ASP_CNT_W-1:0] load_value;
  wire timer_zero;
  reg power_loaded;
  wire select_any;
  wire settle_zero;
  wire take;
  wire read_done;
  wire write_done;

  assign select_any = !select_low_active_b_o || select_high_active_o;
  assign take = (state == ST_IDLE) && (next_state == ST_READ || next_state == ST_WRITE);
  assign read_done = (state == ST_READ) && timer_zero;
  assign write_done = (state == ST_WRITE) && timer_zero;

  assign req_ready_o = (state == ST_IDLE) && !retention_req_i;

  asp_down_counter #(
    .WIDTH(`ASP_CNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .load_i(load),
    .value_i(load_value),
    .zero_o(timer_zero)
  );

  asp_down_counter #(
    .WIDTH(`ASP_CNT_W)
  ) u_settle (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .load_i(select_any),
    .value_i(LOAD_SETTLE),
    .zero_o(settle_zero)
  );

  always @* begin
    next_state = state;
    load = 1'b0;
    load_value = LOAD_ACCESS;
    case (state)
      ST_POWER: begin
        if (!power_loaded) begin
          load = 1'b1;
          load_value = LOAD_POWER;
        end else if (timer_zero) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (retention_req_i) begin
          next_state = ST_RETAIN;
        end else if (req_valid_i) begin
          load = 1'b1;
          if (req_write_i) begin
            load_value = LOAD_WRITE;
            next_state = ST_WRITE;
          end else begin
            next_state = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (timer_zero) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // strobe held for float plus setup.
        if (timer_zero) begin
          next_state = ST_WREND;
        end
      end
      ST_WREND: begin
        next_state = ST_IDLE;
      end
      ST_RETAIN: begin
        if (!retention_req_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_POWER;
      power_loaded <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      power_loaded <= 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= {`ASP_DATA_W{1'b0}};
      retention_ok_o <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      // retention allowed once deselected long enough.
      retention_ok_o <= (next_state == ST_RETAIN) && settle_zero;
      if (read_done) begin
        rsp_rdata_o <= shared_data_lines_i;
        rsp_valid_o <= 1'b1;
      end
      if (state == ST_WREND) begin
        rsp_valid_o <= 1'b1;
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      select_low_active_b_o <= 1'b1;
      select_high_active_o <= 1'b0;
      output_enable_b_o <= 1'b1;
      write_strobe_b_o <= 1'b1;
      word_select_lines_o <= {`ASP_ADDR_W{1'b0}};
      shared_data_lines_o <= {`ASP_DATA_W{1'b0}};
      shared_data_lines_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (take) begin
        // address set with the select, never after.
        word_select_lines_o <= req_addr_i;
        shared_data_lines_o <= req_wdata_i;
        select_low_active_b_o <= 1'b0;
        select_high_active_o <= 1'b1;
        write_strobe_b_o <= !req_write_i;
        output_enable_b_o <= req_write_i;
        shared_data_lines_oe_o <= req_write_i;
      end
      if (read_done) begin
        select_low_active_b_o <= 1'b1;
        select_high_active_o <= 1'b0;
        output_enable_b_o <= 1'b1;
      end
      if (write_done) begin
        // strobe ends the write; data still held.
        write_strobe_b_o <= 1'b1;
        select_low_active_b_o <= 1'b1;
        select_high_active_o <= 1'b0;
      end
      if (state == ST_WREND) begin
        // data released one cycle after the write edge.
        shared_data_lines_oe_o <= 1'b0;
      end
      if (state == ST_RETAIN) begin
        select_low_active_b_o <= 1'b1;
        select_high_active_o <= 1'b0;
        output_enable_b_o <= 1'b1;
        write_strobe_b_o <= 1'b1;
        shared_data_lines_oe_o <= 1'b0;
      end
    end
  end
endmodule

// ---- hdl/asp_consts.vh ----
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
`define ASP_ADDR_W 21
`define ASP_DATA_W 8
`define ASP_CLK_PERIOD_PS 5000
`define ASP_POWER_UP_WAIT_US 100
`define ASP_POWER_UP_WAIT_CYC ((`ASP_POWER_UP_WAIT_US * 1000000) / `ASP_CLK_PERIOD_PS)
`define ASP_DESELECT_TO_RETENTION_NS 0
`define ASP_DESELECT_TO_RETENTION_CYC 1
`define ASP_ACCESS_NS 10
`define ASP_ACCESS_CYC (((`ASP_ACCESS_NS * 1000) + `ASP_CLK_PERIOD_PS - 1) / `ASP_CLK_PERIOD_PS)
`define ASP_STROBE_LOW_TO_FLOAT_PS 5000
`define ASP_WRITE_DATA_SETUP_PS 5500
`define ASP_WRITE_PULSE_PS (`ASP_STROBE_LOW_TO_FLOAT_PS + `ASP_WRITE_DATA_SETUP_PS)
`define ASP_WRITE_CYC ((`ASP_WRITE_PULSE_PS + `ASP_CLK_PERIOD_PS - 1) / `ASP_CLK_PERIOD_PS)
`define ASP_CNT_W 16
`endif

// ---- hdl/asp_down_counter.v ----
`timescale 1ns/100ps
module asp_down_counter #(
  parameter WIDTH = 16
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire load_i,
  input wire [WIDTH-1:0] value_i,
  output wire zero_o
);
  reg [WIDTH-1:0] count;
  assign zero_o = (count == {WIDTH{1'b0}});
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (load_i) begin
        count <= value_i;
      end else if (count != {WIDTH{1'b0}}) begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ---- test/asp_mem_model.sv ----
`timescale 1ns/100ps
module asp_mem_model (
  input wire sel_b_i,
  input wire sel_i,
  input wire oe_b_i,
  input wire we_b_i,
  input wire [20:0] a_i,
  input wire [7:0] d_i,
  output wire [7:0] q_o
);
  logic [7:0] mem [0:2097151];
  wire sel = !sel_b_i && sel_i;
  wire wr = sel && !we_b_i;
  always @(negedge wr) begin
    mem[a_i] = d_i;
  end
  wire drv = sel && we_b_i && !oe_b_i;
  assign q_o = drv ? mem[a_i] : ~mem[a_i];
endmodule

// ---- test/asp_host_asserts.sv ----
`timescale 1ns/100ps
module asp_host_asserts (
  input wire clk_i,
  input wire rst_b_i,
  input wire req_ready_o,
  input wire rsp_valid_o,
  input wire retention_ok_o,
  input wire select_low_active_b_o,
  input wire select_high_active_o,
  input wire output_enable_b_o,
  input wire write_strobe_b_o,
  input wire shared_data_lines_oe_o
);
  wire sb = select_low_active_b_o;
  wire oe = output_enable_b_o;
  wire we = write_strobe_b_o;
  wire doe = shared_data_lines_oe_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_sel_pair:
    assert property (sb == !select_high_active_o) else $error("selects disagree");
  a_write_sel:
    assert property (!we |-> !sb && doe) else $error("write outside select");
  a_end_same:
    assert property ($rose(we) |-> $rose(sb) && doe) else $error("write end wrong");
  a_write_len:
    assert property ($fell(we) |-> !we[*3] ##1 we) else $error("write length wrong");
  a_read_we:
    assert property (!oe |-> we && !doe) else $error("read with strobe or drive");
  a_read_len:
    assert property ($fell(oe) |-> ##2 $rose(oe) && rsp_valid_o) else $error("read length");
  a_ret_desel:
    assert property (retention_ok_o |-> sb && !req_ready_o) else $error("retention selected");
  a_idle_float:
    assert property (req_ready_o |-> sb && !doe) else $error("idle not floating");
endmodule
bind asp_host asp_host_asserts u_asp_host_asserts (.clk_i, .rst_b_i, .req_ready_o,
  .rsp_valid_o, .retention_ok_o, .select_low_active_b_o, .select_high_active_o,
  .output_enable_b_o, .write_strobe_b_o, .shared_data_lines_oe_o);

// ---- test/tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic clk_i = 0, rst_b_i = 0, vld = 0, wr = 0, ret = 0, ce = 1;
  logic [20:0] adr = 0;
  logic [7:0] wd = 0;
  wire rdy, rv, rok, sb, sh, oe, we, doe;
  wire [20:0] wa;
  wire [7:0] hq, mq, rd;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  asp_host #(.POWER_UP_CYC(20)) u_asp_host (.clk_i, .rst_b_i, .ce_i(ce), .req_valid_i(vld),
    .req_write_i(wr), .req_addr_i(adr), .req_wdata_i(wd), .req_ready_o(rdy), .rsp_valid_o(rv),
    .rsp_rdata_o(rd), .retention_req_i(ret), .retention_ok_o(rok),
    .select_low_active_b_o(sb), .select_high_active_o(sh), .output_enable_b_o(oe),
    .write_strobe_b_o(we), .word_select_lines_o(wa), .shared_data_lines_i(doe ? hq : mq),
    .shared_data_lines_o(hq), .shared_data_lines_oe_o(doe));
  asp_mem_model u_asp_mem_model (.sel_b_i(sb), .sel_i(sh), .oe_b_i(oe), .we_b_i(we),
    .a_i(wa), .d_i(hq), .q_o(mq));
  task automatic acc(input logic w, input logic [20:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n++ < 50) @(negedge clk_i);
    vld = 1;
    wr = w;
    adr = a;
    wd = d;
    @(negedge clk_i);
    vld = 0;
    `CHK("select_b", 1'b0, sb)
    `CHK("addr", a, wa)
    `CHK("wdata", d, hq)
    `CHK("drive", w, doe)
    `CHK("strobe_b", !w, we)
    while (rv !== 1'b1 && n++ < 50) @(negedge clk_i);
    `CHK("rsp_valid", 1'b1, rv)
    @(negedge clk_i);
  endtask
  task automatic t_rw;
    logic [20:0] a [3];
    a = '{21'h000000, 21'h1FFFFF, 21'h0A5A5A};
    for (int i = 0; i < 3; i++) acc(1, a[i], 8'hA5 ^ 8'(i * 8'h3C));
    for (int i = 0; i < 3; i++) begin
      acc(0, a[i], 8'h00);
      `CHK("rdata", 8'hA5 ^ 8'(i * 8'h3C), rd)
    end
    $display("t_rw done");
  endtask
  task automatic t_ret;
    ret = 1;
    repeat (2) @(negedge clk_i);
    `CHK("retention_ok", 1'b1, rok)
    `CHK("ready", 1'b0, rdy)
    `CHK("select_b", 1'b1, sb)
    ret = 0;
    acc(0, 21'h1FFFFF, 8'h00);
    `CHK("rdata", 8'hA5 ^ 8'h3C, rd)
    $display("t_ret done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (++cyc == 3000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1;
    repeat (5) @(negedge clk_i);
    ce = 0;
    repeat (10) @(negedge clk_i);
    `CHK("frozen_ready", 1'b0, rdy)
    ce = 1;
    repeat (16) @(negedge clk_i);
    `CHK("ready", 1'b0, rdy)
    @(negedge clk_i);
    `CHK("ready", 1'b1, rdy)
    $display("t_power done");
    t_rw;
    t_ret;
    close_out;
  end
endmodule
